/* File: hw/pwr_regs.svh */
`ifndef PWR_REGS_SVH
`define PWR_REGS_SVH
// ==========================================
// Timing
`define CLK_PERIOD_NS 10
`define TICK_NS 1000000
`define PWR_HOLD_S 4
`define FAN_WIN_MS 100
`define SYNC_SETTLE 2'h3
// ==========================================
// Register offsets
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_STATUS 8'h08
`define REG_WAKE_SRC 8'h0c
`define REG_FAN_TGT 8'h10
// ==========================================
// Control fields and reset values
`define CTRL_RING_EN 0
`define CTRL_PCI_WAKE 1
`define CTRL_PME_S5 2
`define CTRL_NET_S5 3
`define CTRL_FAN_LOOP 4
`define CTRL_LED_DUAL 5
`define CTRL_BTN_RAM 6
`define CTRL_RST 8'h23
`define FAN_TGT_RST 8'h20
`define FAN_DUTY_MAX 4'hf
// ==========================================
// Status fields
`define STAT_PEND_BIT 8
`define STAT_LAST_BIT 9
// ==========================================
// Command and policy codes
`define CMD_S1 3'h1
`define CMD_S3 3'h3
`define CMD_S4 3'h4
`define CMD_S5 3'h5
`define POLICY_ON 2'h1
`define POLICY_LAST 2'h2
// ==========================================
// Pin synchroniser idle levels
`define PIN_IDLE 9'h021
`endif

/* File: hw/pwr_pkg.sv */
package pwr_pkg;
	// ==========================================
	// Power states, one-hot.
	typedef enum logic [4:0] {
		st_work = 5'b00001,
		st_stop = 5'b00010,
		st_ram = 5'b00100,
		st_disk = 5'b01000,
		st_soft_off = 5'b10000
	} pstate_t;
	// Register port request.
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	// Raw wake pins.
	typedef struct packed {
		logic ring;
		logic usb;
		logic kbd_mouse;
		logic net;
		logic pci_power_event_n;
	} wake_pins_t;
	// Qualified wake sources.
	typedef struct packed {
		logic button;
		logic pme;
		logic net;
		logic kbd_mouse;
		logic usb;
		logic ring;
	} wake_src_t;
endpackage : pwr_pkg

/* File: hw/fan_loop.sv */
`timescale 1ns/100ps
`include "pwr_regs.svh"
module fan_loop #(
	parameter int NFANS = 3,
	parameter int WIN_MS = `FAN_WIN_MS
) (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic nrst_in,
	// Control.
	input wire logic tick_in,
	input wire logic run_in,
	input wire logic loop_en_in,
	input wire logic [7:0] target_in,
	// Fans.
	input wire logic [NFANS-1:0] tach_in,
	output logic [NFANS-1:0] fan_power_out
);
	// ==========================================
	// Measurement window and PWM base.
	logic [31:0] win_cnt_r;
	logic [3:0] pwm_cnt_r;
	logic win_end;
	assign win_end = tick_in && (win_cnt_r == 32'(WIN_MS - 1));

	// Window counter runs on the millisecond tick.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			win_cnt_r <= 32'h0;
		end else if (win_end) begin
			win_cnt_r <= 32'h0;
		end else if (tick_in) begin
			win_cnt_r <= win_cnt_r + 32'h1;
		end
	end

	// Free-running PWM phase shared by all fans.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pwm_cnt_r <= 4'h0;
		end else begin
			pwm_cnt_r <= pwm_cnt_r + 4'h1;
		end
	end

	// ==========================================
	// Per-fan tachometer loop.
	genvar i;
	generate
		for (i = 0; i < NFANS; i++) begin : g_fan
			logic t1_r, t2_r, t3_r;
			logic [7:0] cnt_r;
			logic [3:0] duty_r;
			// Two flops take the tach pin; the third only serves edge detection.
			always_ff @(posedge mclk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					t1_r <= 1'b0;
					t2_r <= 1'b0;
					t3_r <= 1'b0;
				end else begin
					t1_r <= tach_in[i];
					t2_r <= t1_r;
					t3_r <= t2_r;
				end
			end
			// Pulses per window; saturates so a racing fan cannot wrap to slow.
			always_ff @(posedge mclk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					cnt_r <= 8'h0;
				end else if (win_end) begin
					cnt_r <= 8'h0;
				end else if (t2_r && !t3_r && cnt_r != 8'hff) begin
					cnt_r <= cnt_r + 8'h1;
				end
			end
			// Duty steps toward the target; duty zero switches the fan off.
			always_ff @(posedge mclk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					duty_r <= `FAN_DUTY_MAX;
				end else if (!loop_en_in) begin
					duty_r <= `FAN_DUTY_MAX;
				end else if (win_end) begin
					if (cnt_r < target_in && duty_r != `FAN_DUTY_MAX) begin
						duty_r <= duty_r + 4'h1;
					end else if (cnt_r > target_in && duty_r != 4'h0) begin
						duty_r <= duty_r - 4'h1;
					end
				end
			end
			// Power only while running; the loop only trims within that.
			always_ff @(posedge mclk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					fan_power_out[i] <= 1'b0;
				end else begin
					fan_power_out[i] <= run_in && (!loop_en_in || duty_r == `FAN_DUTY_MAX || pwm_cnt_r < duty_r);
				end
			end
		end
	endgenerate
endmodule : fan_loop

/* File: hw/wake_and_fan_power_control.sv */
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/100ps
`include "pwr_regs.svh"
module wake_and_fan_power_control #(
	parameter int TICK_CYC = `TICK_NS / `CLK_PERIOD_NS,
	parameter int HOLD_MS = `PWR_HOLD_S * 1000,
	parameter int NFANS = 3
) (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic nrst_in,
	// Register port.
	input wire pwr_pkg::reg_req_t reg_req_in,
	output logic [31:0] reg_rdata_out,
	// Wake pins and power button.
	input wire pwr_pkg::wake_pins_t wake_pins_in,
	input wire logic pwr_button_n_in,
	// Restore policy strap and standby storage.
	input wire logic [1:0] restore_policy_in,
	input wire logic saved_on_in,
	output logic last_on_out,
	// Fans.
	input wire logic [NFANS-1:0] fan_tach_in,
	output logic [NFANS-1:0] fan_power_out,
	// Supply and indicators.
	output logic supply_on_out,
	output logic led_green_out,
	output logic led_amber_out,
	output logic standby_led_out,
	output logic wake_pending_out
);
	import pwr_pkg::*;

	// ==========================================
	// Pin synchronisers.
	logic [8:0] pin_raw, sync1_r, sync2_r;
	logic ring_s, usb_s, kbd_s, net_s, pme_s, btn_s, saved_s;
	logic [1:0] policy_s;
	assign pin_raw = {saved_on_in, restore_policy_in, pwr_button_n_in, wake_pins_in};
	assign {saved_s, policy_s} = sync2_r[8:6];
	assign btn_s = !sync2_r[5];
	assign {ring_s, usb_s, kbd_s, net_s} = sync2_r[4:1];
	assign pme_s = !sync2_r[0];

	// Every pin passes two flops before any decision sees it.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sync1_r <= `PIN_IDLE;
			sync2_r <= `PIN_IDLE;
		end else begin
			sync1_r <= pin_raw;
			sync2_r <= sync1_r;
		end
	end

	// ==========================================
	// Millisecond enable.
	logic [31:0] tick_cnt_r;
	logic tick_r;
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tick_cnt_r <= 32'h0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (tick_cnt_r == 32'(TICK_CYC - 1));
			tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYC - 1)) ? 32'h0 : tick_cnt_r + 32'h1;
		end
	end

	// ==========================================
	// Register port.
	logic [7:0] ctrl_r, fan_tgt_r;
	wake_src_t wake_src_r, wake_q;
	pstate_t state_r, state_nxt;
	logic pend_r, last_on_r, cmd_valid;
	logic [2:0] cmd_code;
	logic [31:0] rd_mux;
	assign cmd_valid = reg_req_in.wr && reg_req_in.addr == `REG_CMD;
	assign cmd_code = reg_req_in.wdata[2:0];

	// Control and fan target are plain read/write words.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_r <= `CTRL_RST;
			fan_tgt_r <= `FAN_TGT_RST;
		end else if (reg_req_in.wr) begin
			if (reg_req_in.addr == `REG_CTRL) begin
				ctrl_r <= reg_req_in.wdata[7:0];
			end
			if (reg_req_in.addr == `REG_FAN_TGT) begin
				fan_tgt_r <= reg_req_in.wdata[7:0];
			end
		end
	end

	// Read mux; unmapped offsets and the command word read as zero.
	always_comb begin
		rd_mux = 32'h0;
		unique case (reg_req_in.addr)
			`REG_CTRL: rd_mux[7:0] = ctrl_r;
			`REG_STATUS: begin
				rd_mux[4:0] = state_r;
				rd_mux[`STAT_PEND_BIT] = pend_r;
				rd_mux[`STAT_LAST_BIT] = last_on_r;
			end
			`REG_WAKE_SRC: rd_mux[5:0] = wake_src_r;
			`REG_FAN_TGT: rd_mux[7:0] = fan_tgt_r;
			default: rd_mux = 32'h0;
		endcase
	end

	// Read data stand for exactly the cycle after the strobe.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			reg_rdata_out <= 32'h0;
		end else begin
			reg_rdata_out <= reg_req_in.rd ? rd_mux : 32'h0;
		end
	end

	// ==========================================
	// Power button timing.
	logic [31:0] btn_ms_r;
	logic btn_prev_r, long_done_r, long_hit, short_press;
	assign long_hit = btn_s && tick_r && !long_done_r && btn_ms_r == 32'(HOLD_MS - 1);
	assign short_press = btn_prev_r && !btn_s && !long_done_r;

	// A release after a long hold is swallowed so it cannot also wake.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			btn_ms_r <= 32'h0;
			btn_prev_r <= 1'b0;
			long_done_r <= 1'b0;
		end else begin
			btn_prev_r <= btn_s;
			if (!btn_s && !btn_prev_r) begin
				btn_ms_r <= 32'h0;
				long_done_r <= 1'b0;
			end else if (long_hit) begin
				long_done_r <= 1'b1;
			end else if (btn_s && tick_r && !long_done_r) begin
				btn_ms_r <= btn_ms_r + 32'h1;
			end
		end
	end

	// ==========================================
	// Wake qualification.
	logic in_s1s3, deep_ok, soft_off;
	assign in_s1s3 = state_r == st_stop || state_r == st_ram;
	assign deep_ok = in_s1s3 || state_r == st_disk;
	assign soft_off = state_r == st_soft_off;

	// Each source is gated by the states it may wake from; ring and PCI events also by their enable bits.
	always_comb begin
		wake_q.ring = ring_s && ctrl_r[`CTRL_RING_EN] && in_s1s3;
		wake_q.usb = usb_s && in_s1s3;
		wake_q.kbd_mouse = kbd_s && in_s1s3;
		wake_q.net = net_s && (deep_ok || (soft_off && ctrl_r[`CTRL_NET_S5]));
		wake_q.pme = pme_s && ctrl_r[`CTRL_PCI_WAKE] && (deep_ok || (soft_off && ctrl_r[`CTRL_PME_S5]));
		wake_q.button = short_press && state_r != st_work;
	end

	// Merged request holds until the working state is reached.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pend_r <= 1'b0;
		end else if (|wake_q) begin
			pend_r <= 1'b1;
		end else if (state_r == st_work) begin
			pend_r <= 1'b0;
		end
	end

	// Sticky per-source record; a new event beats a write-one clear.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wake_src_r <= '0;
		end else if (reg_req_in.wr && reg_req_in.addr == `REG_WAKE_SRC) begin
			wake_src_r <= (wake_src_r & ~reg_req_in.wdata[5:0]) | wake_q;
		end else begin
			wake_src_r <= wake_src_r | wake_q;
		end
	end

	// ==========================================
	// Power state machine.
	logic [1:0] settle_r;
	logic restored_r;
	pstate_t btn_sleep;
	assign btn_sleep = ctrl_r[`CTRL_BTN_RAM] ? st_ram : st_stop;

	// Restore waits for the synchronisers to carry real strap levels.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			settle_r <= 2'h0;
			restored_r <= 1'b0;
		end else if (settle_r != `SYNC_SETTLE) begin
			settle_r <= settle_r + 2'h1;
		end else begin
			restored_r <= 1'b1;
		end
	end

	always_comb begin
		state_nxt = state_r;
		if (!restored_r) begin
			if (settle_r == `SYNC_SETTLE && (policy_s == `POLICY_ON || (policy_s == `POLICY_LAST && saved_s))) begin
				state_nxt = st_work;
			end
		end else begin
			unique case (state_r)
				st_work: begin
					if (long_hit) begin
						state_nxt = st_soft_off;
					end else if (cmd_valid && cmd_code == `CMD_S5) begin
						state_nxt = st_soft_off;
					end else if (cmd_valid && cmd_code == `CMD_S4) begin
						state_nxt = st_disk;
					end else if (cmd_valid && cmd_code == `CMD_S3) begin
						state_nxt = st_ram;
					end else if (cmd_valid && cmd_code == `CMD_S1) begin
						state_nxt = st_stop;
					end else if (short_press) begin
						state_nxt = btn_sleep;
					end
				end
				st_stop, st_ram, st_disk: begin
					if (long_hit) begin
						state_nxt = st_soft_off;
					end else if (pend_r) begin
						state_nxt = st_work;
					end
				end
				st_soft_off: begin
					if (pend_r) begin
						state_nxt = st_work;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_r <= st_soft_off;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Standby record: on at power-up, off at soft-off, saved standby value at restore.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			last_on_r <= 1'b0;
		end else if (!restored_r) begin
			last_on_r <= saved_s;
		end else if (state_nxt == st_work) begin
			last_on_r <= 1'b1;
		end else if (state_nxt == st_soft_off) begin
			last_on_r <= 1'b0;
		end
	end

	// ==========================================
	// Outputs.
	logic fan_run;
	assign fan_run = state_r == st_work || state_r == st_stop;

	// Supply and the green and amber indicators follow the state one cycle later; the standby indicator stays lit.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			supply_on_out <= 1'b0;
			led_green_out <= 1'b0;
			led_amber_out <= 1'b0;
			standby_led_out <= 1'b0;
		end else begin
			supply_on_out <= fan_run;
			led_green_out <= state_r == st_work;
			led_amber_out <= ctrl_r[`CTRL_LED_DUAL] && in_s1s3;
			standby_led_out <= 1'b1;
		end
	end
	assign wake_pending_out = pend_r;
	assign last_on_out = last_on_r;

	fan_loop #(.NFANS(NFANS)) u_fans (
		.mclk_in(mclk_in),
		.nrst_in(nrst_in),
		.tick_in(tick_r),
		.run_in(fan_run),
		.loop_en_in(ctrl_r[`CTRL_FAN_LOOP]),
		.target_in(fan_tgt_r),
		.tach_in(fan_tach_in),
		.fan_power_out(fan_power_out)
	);

	// ==========================================
	// Checks.
	chk_fans_off_sleep: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		!fan_run |=> fan_power_out == '0) else $error("fan powered while off or deep asleep");
	chk_fans_on_run: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		fan_run && !ctrl_r[`CTRL_FAN_LOOP] |=> fan_power_out == '1) else $error("fan unpowered while running");
	chk_soft_off_cmd: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		restored_r && state_r == st_work && !long_hit && cmd_valid && cmd_code == `CMD_S5
		|=> state_r == st_soft_off ##1 !supply_on_out) else $error("soft-off command did not drop supply");
	chk_ram_indicator: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		state_r == st_ram && ctrl_r[`CTRL_LED_DUAL] |=> led_amber_out && !supply_on_out) else $error("bad S3 indicator");
	chk_ram_wake: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		restored_r && state_r == st_ram && pend_r && !long_hit |=> state_r == st_work) else $error("S3 wake not taken");
	chk_pend_clear: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		state_r == st_work |=> !pend_r) else $error("wake request held in working state");
	chk_pme_disk: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		restored_r && state_r == st_disk && pme_s && ctrl_r[`CTRL_PCI_WAKE] && !long_hit
		|=> pend_r ##1 state_r == st_work) else $error("PCI event failed to wake from S4");
	chk_net_s5_off: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		soft_off && !pend_r && !ctrl_r[`CTRL_NET_S5] && !pme_s && !short_press |=> !pend_r)
		else $error("network wake taken from soft-off while disabled");
	chk_long_press: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		restored_r && long_hit |=> state_r == st_soft_off) else $error("long press did not force soft-off");
	chk_standby_lit: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		$past(nrst_in) |-> standby_led_out) else $error("standby indicator dark");
endmodule : wake_and_fan_power_control

/* File: sim/wake_peer.sv */
`timescale 1ns/100ps
module wake_peer (
	// Clock.
	input wire logic mclk_in,
	// Wake pins and power button toward the controller.
	output pwr_pkg::wake_pins_t pins_out,
	output logic button_n_out
);
	import pwr_pkg::*;
	// ==========================================
	// Peripheral side
	// Event lines idle low; the PCI event line is active low, so it idles high.
	localparam logic [4:0] idle_lvl = 5'h01;
	// Pins rest at their idle levels from time zero.
	initial begin
		pins_out = wake_pins_t'(idle_lvl);
		button_n_out = 1'b1;
	end
	// A peripheral raises its event for n cycles; modem rings of both kinds share the ring line.
	task pulse(input logic [4:0] m, input int n);
		@(posedge mclk_in);
		pins_out <= wake_pins_t'(idle_lvl ^ m);
		repeat (n) @(posedge mclk_in);
		pins_out <= wake_pins_t'(idle_lvl);
	endtask : pulse
	// The user holds the button low for n cycles, long enough to cross the synchroniser.
	task press(input int n);
		@(posedge mclk_in);
		button_n_out <= 1'b0;
		repeat (n) @(posedge mclk_in);
		button_n_out <= 1'b1;
	endtask : press
endmodule : wake_peer

/* File: sim/wake_and_fan_power_control_tb.sv */
`timescale 1ns/100ps
`include "pwr_regs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("ERROR %0t: got %0h want %0h", $time, (g), (e)); end end
module wake_and_fan_power_control_tb;
	import pwr_pkg::*;
	// ==========================================
	// Stimulus and observed signals
	localparam logic [4:0] m_ring = 5'h10;
	localparam logic [4:0] m_usb = 5'h08;
	localparam logic [4:0] m_kbd = 5'h04;
	localparam logic [4:0] m_net = 5'h02;
	localparam logic [4:0] m_pme = 5'h01;
	logic mclk_in = 1'b0;
	logic nrst_in = 1'b0;
	reg_req_t req = '0;
	logic [1:0] policy = 2'h0;
	logic saved = 1'b0;
	wake_pins_t pins;
	logic btn_n;
	logic [31:0] rdata;
	logic [31:0] v;
	logic last_on, supply, green, amber, sled, pend;
	logic [2:0] fans;
	logic tach = 1'b0;
	logic tach_run = 1'b0;
	int failures = 0;
	int checked = 0;
	// Free-running 100 MHz clock.
	always #5 mclk_in = ~mclk_in;
	// Tach pulses for all three fans; one rising edge every two cycles while enabled.
	always @(posedge mclk_in) begin
		if (tach_run) begin
			tach <= ~tach;
		end
	end
	// Short tick and hold counts keep a long press at twelve cycles.
	wake_and_fan_power_control #(.TICK_CYC(4), .HOLD_MS(3), .NFANS(3)) uut (
		.mclk_in(mclk_in), .nrst_in(nrst_in), .reg_req_in(req), .reg_rdata_out(rdata),
		.wake_pins_in(pins), .pwr_button_n_in(btn_n), .restore_policy_in(policy),
		.saved_on_in(saved), .last_on_out(last_on), .fan_tach_in({3{tach}}), .fan_power_out(fans),
		.supply_on_out(supply), .led_green_out(green), .led_amber_out(amber),
		.standby_led_out(sled), .wake_pending_out(pend)
	);
	wake_peer peer (.mclk_in(mclk_in), .pins_out(pins), .button_n_out(btn_n));
	// ==========================================
	// Bus and helper tasks
	task test_done;
		$display("TB: %0d compared, %0d mismatched", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done
	task reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk_in);
		req.wr <= 1'b0;
	endtask : reg_wr
	// Read data is valid only in the cycle after the strobe, so it is taken just past that edge.
	task reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_in);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk_in);
		req.rd <= 1'b0;
		#1 d = rdata;
	endtask : reg_rd
	task chk_st(input logic [4:0] s, input logic on);
		reg_rd(`REG_STATUS, v);
		`CHK(v[4:0], s)
		`CHK(supply, on)
		`CHK(fans, {3{on}})
	endtask : chk_st
	task cmd(input logic [2:0] c);
		reg_wr(`REG_CMD, {29'h0, c});
		repeat (3) @(posedge mclk_in);
	endtask : cmd
	task ev(input logic [4:0] m);
		peer.pulse(m, 6);
		repeat (3) @(posedge mclk_in);
	endtask : ev
	task btn(input int n);
		peer.press(n);
		repeat (8) @(posedge mclk_in);
	endtask : btn
	task do_reset(input logic [1:0] p, input logic s);
		@(posedge mclk_in);
		nrst_in <= 1'b0;
		policy <= p;
		saved <= s;
		repeat (11) @(posedge mclk_in);
		nrst_in <= 1'b1;
		repeat (10) @(posedge mclk_in);
	endtask : do_reset
	// ==========================================
	// Scenarios
	task t_reset;
		do_reset(2'h0, 1'b0);
		#1 `CHK(sled, 1'b1)
		reg_rd(`REG_CTRL, v);
		`CHK(v, 32'h23)
		reg_rd(`REG_FAN_TGT, v);
		`CHK(v, 32'h20)
		reg_rd(8'h14, v);
		`CHK(v, 32'h0)
		chk_st(5'h10, 1'b0);
		`CHK(last_on, 1'b0)
		$display("TB: reset test done");
	endtask : t_reset
	task t_button;
		btn(4);
		chk_st(5'h01, 1'b1);
		`CHK(last_on, 1'b1)
		`CHK(green, 1'b1)
		btn(4);
		chk_st(5'h02, 1'b1);
		`CHK(amber, 1'b1)
		btn(4);
		chk_st(5'h01, 1'b1);
		$display("TB: button test done");
	endtask : t_button
	task t_s1;
		reg_wr(`REG_WAKE_SRC, 32'h3f);
		cmd(`CMD_S1);
		chk_st(5'h02, 1'b1);
		ev(m_usb);
		chk_st(5'h01, 1'b1);
		`CHK(pend, 1'b0)
		reg_rd(`REG_WAKE_SRC, v);
		`CHK(v[5:0], 6'h02)
		$display("TB: processor-stopped test done");
	endtask : t_s1
	task t_s3;
		cmd(`CMD_S3);
		chk_st(5'h04, 1'b0);
		`CHK({green, amber}, 2'b01)
		reg_wr(`REG_CTRL, 32'h22);
		ev(m_ring);
		chk_st(5'h04, 1'b0);
		reg_wr(`REG_CTRL, 32'h23);
		ev(m_ring);
		chk_st(5'h01, 1'b1);
		reg_wr(`REG_WAKE_SRC, 32'h3f);
		ev(m_ring);
		ev(m_kbd);
		reg_rd(`REG_WAKE_SRC, v);
		`CHK(v[5:0], 6'h00)
		cmd(`CMD_S3);
		ev(m_kbd);
		chk_st(5'h01, 1'b1);
		$display("TB: suspend-to-RAM test done");
	endtask : t_s3
	task t_s4;
		cmd(`CMD_S4);
		chk_st(5'h08, 1'b0);
		ev(m_usb);
		ev(m_kbd);
		ev(m_ring);
		chk_st(5'h08, 1'b0);
		ev(m_net);
		chk_st(5'h01, 1'b1);
		cmd(`CMD_S4);
		reg_wr(`REG_WAKE_SRC, 32'h3f);
		ev(m_pme);
		chk_st(5'h01, 1'b1);
		reg_rd(`REG_WAKE_SRC, v);
		`CHK(v[5:0], 6'h10)
		$display("TB: suspend-to-disk test done");
	endtask : t_s4
	task t_s5;
		cmd(3'h2);
		chk_st(5'h01, 1'b1);
		cmd(`CMD_S5);
		chk_st(5'h10, 1'b0);
		`CHK(last_on, 1'b0)
		ev(m_pme);
		ev(m_net);
		chk_st(5'h10, 1'b0);
		reg_wr(`REG_CTRL, 32'h2f);
		ev(m_pme);
		chk_st(5'h01, 1'b1);
		cmd(`CMD_S5);
		ev(m_net);
		chk_st(5'h01, 1'b1);
		reg_wr(`REG_CTRL, 32'h23);
		$display("TB: soft-off test done");
	endtask : t_s5
	// Fast tach against a zero target walks every duty down to zero, so the fans stop while running.
	task t_fan;
		tach_run <= 1'b1;
		reg_wr(`REG_FAN_TGT, 32'h0);
		reg_wr(`REG_CTRL, 32'h33);
		repeat (6500) @(posedge mclk_in);
		#1 `CHK(fans, 3'h0)
		`CHK(supply, 1'b1)
		reg_wr(`REG_CTRL, 32'h23);
		repeat (3) @(posedge mclk_in);
		#1 `CHK(fans, 3'h7)
		tach_run <= 1'b0;
		reg_wr(`REG_FAN_TGT, 32'h20);
		$display("TB: fan loop test done");
	endtask : t_fan
	task t_long;
		btn(24);
		chk_st(5'h10, 1'b0);
		btn(4);
		cmd(`CMD_S1);
		btn(24);
		chk_st(5'h10, 1'b0);
		$display("TB: long press test done");
	endtask : t_long
	task t_restore;
		do_reset(`POLICY_ON, 1'b0);
		chk_st(5'h01, 1'b1);
		do_reset(`POLICY_LAST, 1'b1);
		chk_st(5'h01, 1'b1);
		`CHK(last_on, 1'b1)
		do_reset(`POLICY_LAST, 1'b0);
		chk_st(5'h10, 1'b0);
		`CHK(last_on, 1'b0)
		do_reset(2'h3, 1'b1);
		chk_st(5'h10, 1'b0);
		$display("TB: restore test done");
	endtask : t_restore
	// ==========================================
	// Main sequence and watchdog
	initial begin
		t_reset();
		t_button();
		t_s1();
		t_s3();
		t_s4();
		t_s5();
		t_fan();
		t_long();
		t_restore();
		test_done();
	end
	// The tests need about 7000 cycles, mostly the fan windows; the watchdog allows several times that.
	initial begin
		#400us;
		failures++;
		$display("ERROR %0t: watchdog expired", $time);
		test_done();
	end
endmodule : wake_and_fan_power_control_tb
